// >>> logic/measurement_mode_pkg.sv
// Function
// - line-period measurement follows phase chosen by bits 1:0; code 11 reserved; resets 0
// - voltage and current peak detection follow phase chosen by bits 3:2; resets 0
// - voltage peak flag sets when selected phase voltage exceeds its threshold
// - current peak flag sets when selected phase current exceeds its threshold
// - bits 6:4 enable phases A, B, C for zero-crossing counting; reset 7
// - zero-crossing and period functions apply only to enabled phases
package measurement_mode_pkg;

  localparam int         ADDR_W              = 6;
  localparam int         DATA_W              = 8;
  localparam int         SAMPLE_W            = 16;
  localparam int         PHASES              = 3;

  localparam logic [5:0] MEASUREMENT_MODE_ADDR = 6'h0B;

  localparam int         PERIOD_SEL_LSB      = 0;
  localparam int         PEAK_SEL_LSB        = 2;
  localparam int         ZERO_CROSS_EN_LSB   = 4;
  localparam int         RESERVED_BIT        = 7;

  localparam logic [1:0] PERIOD_SEL_RESET    = 2'h0;
  localparam logic [1:0] PEAK_SEL_RESET      = 2'h0;
  localparam logic [2:0] ZERO_CROSS_EN_RESET = 3'h7;
  localparam logic [1:0] PHASE_SEL_RESERVED  = 2'h3;

  typedef struct packed {
    logic       reserved;
    logic [2:0] zero_cross_phase_enable;
    logic [1:0] peak_source_select;
    logic [1:0] period_source_select;
  } measurement_mode_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] voltage;
    logic [SAMPLE_W-1:0] current;
  } phase_sample_t;

  localparam measurement_mode_t MEASUREMENT_MODE_RESET = '{
    reserved:                1'b0,
    zero_cross_phase_enable: ZERO_CROSS_EN_RESET,
    peak_source_select:      PEAK_SEL_RESET,
    period_source_select:    PERIOD_SEL_RESET
  };

endpackage : measurement_mode_pkg

// >>> logic/measurement_mode_select.sv
`timescale 1ns/100ps
module measurement_mode_select
  import measurement_mode_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  // register port
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire logic [ADDR_W-1:0]         reg_addr_i,
  input  wire logic [DATA_W-1:0]         reg_wdata_i,
  output logic      [DATA_W-1:0]         reg_rdata_o,
  // measurement datapath
  input  wire logic [PHASES-1:0]         zero_cross_i,
  input  wire phase_sample_t [PHASES-1:0] sample_i,
  input  wire logic [SAMPLE_W-1:0]       voltage_peak_threshold_i,
  input  wire logic [SAMPLE_W-1:0]       current_peak_threshold_i,
  // results
  output measurement_mode_t              measurement_mode_o,
  output logic                           period_zero_cross_o,
  output logic                           voltage_peak_flag_o,
  output logic                           current_peak_flag_o,
  output logic      [PHASES-1:0]         zero_cross_gated_o
);

  measurement_mode_t         mode;
  measurement_mode_t         next_mode;
  logic [DATA_W-1:0]         next_rdata;
  logic                      next_period_zc;
  logic                      next_v_peak;
  logic                      next_i_peak;
  logic [PHASES-1:0]         next_zc_gated;
  phase_sample_t             peak_sample;

  // true when the code names a phase
  function automatic logic phase_valid(input logic [1:0] code);
    phase_valid = (code != PHASE_SEL_RESERVED);
  endfunction : phase_valid

  // register write and read
  always_comb begin
    next_mode  = mode;
    next_rdata = '0;
    if (reg_wr_i && reg_addr_i == MEASUREMENT_MODE_ADDR) begin
      next_mode          = measurement_mode_t'(reg_wdata_i);
      next_mode.reserved = 1'b0;
    end
    if (reg_rd_i && reg_addr_i == MEASUREMENT_MODE_ADDR) begin
      next_rdata               = mode;
      next_rdata[RESERVED_BIT] = 1'b0;
    end
  end

  // phase routing and peak compare
  always_comb begin
    peak_sample    = '0;
    next_zc_gated  = zero_cross_i & mode.zero_cross_phase_enable;
    next_period_zc = 1'b0;
    if (phase_valid(mode.period_source_select)) begin
      next_period_zc = next_zc_gated[mode.period_source_select];
    end
    if (phase_valid(mode.peak_source_select)) begin
      peak_sample = sample_i[mode.peak_source_select];
    end
    next_v_peak = phase_valid(mode.peak_source_select)
                  && (peak_sample.voltage > voltage_peak_threshold_i);
    next_i_peak = phase_valid(mode.peak_source_select)
                  && (peak_sample.current > current_peak_threshold_i);
  end

  // register group
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode               <= MEASUREMENT_MODE_RESET;
      reg_rdata_o        <= '0;
      measurement_mode_o <= MEASUREMENT_MODE_RESET;
    end else begin
      mode               <= next_mode;
      reg_rdata_o        <= next_rdata;
      measurement_mode_o <= next_mode;
    end
  end

  // datapath group
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      period_zero_cross_o <= 1'b0;
      voltage_peak_flag_o <= 1'b0;
      current_peak_flag_o <= 1'b0;
      zero_cross_gated_o  <= '0;
    end else begin
      period_zero_cross_o <= next_period_zc;
      voltage_peak_flag_o <= next_v_peak;
      current_peak_flag_o <= next_i_peak;
      zero_cross_gated_o  <= next_zc_gated;
    end
  end

  property p_period_source;
    @(posedge clk_i) disable iff (reset_i)
      period_zero_cross_o |-> $past(phase_valid(mode.period_source_select))
        && $past(zero_cross_i[mode.period_source_select])
        && $past(mode.zero_cross_phase_enable[mode.period_source_select]);
  endproperty
  a_period_source: assert property (p_period_source)
    else $error("period event without a valid enabled source");

  property p_peak_reserved;
    @(posedge clk_i) disable iff (reset_i)
      (voltage_peak_flag_o || current_peak_flag_o)
        |-> $past(mode.peak_source_select) != PHASE_SEL_RESERVED;
  endproperty
  a_peak_reserved: assert property (p_peak_reserved)
    else $error("peak flag raised with reserved source");

  property p_voltage_peak;
    @(posedge clk_i) disable iff (reset_i)
      ##1 voltage_peak_flag_o == $past(phase_valid(mode.peak_source_select)
        && sample_i[mode.peak_source_select].voltage > voltage_peak_threshold_i);
  endproperty
  a_voltage_peak: assert property (p_voltage_peak)
    else $error("voltage peak flag disagrees with compare");

  property p_current_peak;
    @(posedge clk_i) disable iff (reset_i)
      ##1 current_peak_flag_o == $past(phase_valid(mode.peak_source_select)
        && sample_i[mode.peak_source_select].current > current_peak_threshold_i);
  endproperty
  a_current_peak: assert property (p_current_peak)
    else $error("current peak flag disagrees with compare");

  property p_reset_value;
    @(posedge clk_i)
      reset_i |=> measurement_mode_o == MEASUREMENT_MODE_RESET
        && reg_rdata_o == '0
        && zero_cross_gated_o == '0
        && !period_zero_cross_o
        && !voltage_peak_flag_o
        && !current_peak_flag_o;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("outputs not at reset value");

  property p_zero_cross_gate;
    @(posedge clk_i) disable iff (reset_i)
      ##1 zero_cross_gated_o == ($past(zero_cross_i) & $past(mode.zero_cross_phase_enable));
  endproperty
  a_zero_cross_gate: assert property (p_zero_cross_gate)
    else $error("zero crossing passed on a disabled phase");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (reset_i)
      reg_rdata_o[RESERVED_BIT] == 1'b0 && measurement_mode_o.reserved == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit reads as one");

  property p_write_readback;
    @(posedge clk_i) disable iff (reset_i)
      (reg_wr_i && reg_addr_i == MEASUREMENT_MODE_ADDR && !reg_rd_i)
        ##1 (reg_rd_i && reg_addr_i == MEASUREMENT_MODE_ADDR && !reg_wr_i)
        |=> reg_rdata_o[6:0] == $past(reg_wdata_i[6:0], 2);
  endproperty
  a_write_readback: assert property (p_write_readback)
    else $error("read back differs from written value");

  property p_write_update;
    @(posedge clk_i) disable iff (reset_i)
      reg_wr_i && reg_addr_i == MEASUREMENT_MODE_ADDR
        |=> measurement_mode_o == {1'b0, $past(reg_wdata_i[RESERVED_BIT-1:0])};
  endproperty
  a_write_update: assert property (p_write_update)
    else $error("write did not reach the mode register");

  property p_mode_hold;
    @(posedge clk_i) disable iff (reset_i)
      !(reg_wr_i && reg_addr_i == MEASUREMENT_MODE_ADDR)
        |=> $stable(measurement_mode_o);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode register changed without a write");

  property p_read_data;
    @(posedge clk_i) disable iff (reset_i)
      reg_rd_i && reg_addr_i == MEASUREMENT_MODE_ADDR
        |=> reg_rdata_o == {1'b0, $past(measurement_mode_o[RESERVED_BIT-1:0])};
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data differs from mode register");

  property p_read_idle;
    @(posedge clk_i) disable iff (reset_i)
      !(reg_rd_i && reg_addr_i == MEASUREMENT_MODE_ADDR)
        |=> reg_rdata_o == '0;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not zero without a read");

  property p_zero_cross_quiet;
    @(posedge clk_i) disable iff (reset_i)
      zero_cross_i == '0
        |=> zero_cross_gated_o == '0 && !period_zero_cross_o;
  endproperty
  a_zero_cross_quiet: assert property (p_zero_cross_quiet)
    else $error("zero crossing output without an input");

  property p_period_reserved;
    @(posedge clk_i) disable iff (reset_i)
      mode.period_source_select == PHASE_SEL_RESERVED
        |=> !period_zero_cross_o;
  endproperty
  a_period_reserved: assert property (p_period_reserved)
    else $error("period event from reserved source");

  property p_period_follow;
    @(posedge clk_i) disable iff (reset_i)
      phase_valid(mode.period_source_select)
        |=> period_zero_cross_o == zero_cross_gated_o[$past(mode.period_source_select)];
  endproperty
  a_period_follow: assert property (p_period_follow)
    else $error("period event not from the selected phase");

endmodule : measurement_mode_select

// >>> dv/host_model.sv
`timescale 1ns/100ps
module host_model
  import measurement_mode_pkg::*;
(
  // clock
  input  wire logic              clk_i,
  // register port
  output logic                   reg_wr_o,
  output logic                   reg_rd_o,
  output logic [ADDR_W-1:0]      reg_addr_o,
  output logic [DATA_W-1:0]      reg_wdata_o
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 6'h00;
    reg_wdata_o = 8'h00;
  end
  // one strobe cycle, driven on the falling edge
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_i);
    reg_wr_o    = wr;
    reg_rd_o    = !wr;
    reg_addr_o  = a;
    reg_wdata_o = d & 8'h7F;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = ~d;
  endtask : access
  // write then read in back-to-back cycles
  task automatic write_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_i);
    reg_wr_o    = 1'b1;
    reg_rd_o    = 1'b0;
    reg_addr_o  = a;
    reg_wdata_o = d & 8'h7F;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b1;
    @(negedge clk_i);
    reg_rd_o    = 1'b0;
    reg_wdata_o = ~d;
  endtask : write_read
endmodule : host_model

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb import measurement_mode_pkg::*;;
  logic                       clk_i      = 1'b0;
  logic                       reset_i    = 1'b1;
  logic                       reg_wr;
  logic                       reg_rd;
  logic [ADDR_W-1:0]          reg_addr;
  logic [DATA_W-1:0]          reg_wdata;
  logic [DATA_W-1:0]          reg_rdata;
  logic [PHASES-1:0]          zero_cross = 3'h0;
  logic [PHASES-1:0]          zx_gated;
  phase_sample_t [PHASES-1:0] sample     = '0;
  logic [SAMPLE_W-1:0]        v_thr      = 16'h1000;
  logic [SAMPLE_W-1:0]        i_thr      = 16'h2000;
  measurement_mode_t          mode;
  logic                       period_zx;
  logic                       v_flag;
  logic                       i_flag;
  int                         n_errors   = 0;
  int                         compares   = 0;
  int                         cycles     = 0;
  always #20 clk_i = ~clk_i;
  host_model host_model_inst (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
  measurement_mode_select measurement_mode_select_inst (.clk_i(clk_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .zero_cross_i(zero_cross), .sample_i(sample),
    .voltage_peak_threshold_i(v_thr), .current_peak_threshold_i(i_thr),
    .measurement_mode_o(mode), .period_zero_cross_o(period_zx), .voltage_peak_flag_o(v_flag),
    .current_peak_flag_o(i_flag), .zero_cross_gated_o(zx_gated));
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_reset;
    chk(mode, 8'h70);
    host_model_inst.access(1'b0, MEASUREMENT_MODE_ADDR, 8'h00);
    chk(reg_rdata, 8'h70);
  endtask : test_reset
  task automatic test_regs;
    host_model_inst.access(1'b1, MEASUREMENT_MODE_ADDR, 8'h26);
    chk(mode, 8'h26);
    host_model_inst.access(1'b0, MEASUREMENT_MODE_ADDR, 8'h00);
    chk(reg_rdata, 8'h26);
    host_model_inst.access(1'b0, 6'h0C, 8'h00);
    chk(reg_rdata, 8'h00);
    host_model_inst.write_read(MEASUREMENT_MODE_ADDR, 8'h59);
    chk(reg_rdata, 8'h59);
    chk(mode, 8'h59);
  endtask : test_regs
  // reset in mid-run brings the register back to its defaults
  task automatic test_mid_reset;
    host_model_inst.access(1'b1, MEASUREMENT_MODE_ADDR, 8'h26);
    chk(mode, 8'h26);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    chk(mode, 8'h70);
    host_model_inst.access(1'b0, MEASUREMENT_MODE_ADDR, 8'h00);
    chk(reg_rdata, 8'h70);
  endtask : test_mid_reset
  // one zero crossing on every phase, gated by the enables
  task automatic test_zx(input logic [7:0] m, input logic [2:0] g, input logic p);
    host_model_inst.access(1'b1, MEASUREMENT_MODE_ADDR, m);
    zero_cross = 3'h7;
    @(negedge clk_i);
    zero_cross = 3'h0;
    chk({5'h0, zx_gated}, {5'h0, g});
    chk({7'h0, period_zx}, {7'h0, p});
  endtask : test_zx
  // selected phase one above threshold (every phase for code 3), the rest exactly at it
  task automatic test_peak(input logic [1:0] s, input logic v);
    host_model_inst.access(1'b1, MEASUREMENT_MODE_ADDR, {4'h7, s, 2'h0});
    sample = {3{v_thr, i_thr}};
    for (int k = 0; k < PHASES; k++)
      if (k == s || s == 2'h3) sample[k] = v ? {v_thr + 16'h1, i_thr} : {v_thr, i_thr + 16'h1};
    @(negedge clk_i);
    chk({7'h0, v_flag}, {7'h0, v && s != 2'h3});
    chk({7'h0, i_flag}, {7'h0, !v && s != 2'h3});
    sample = {3{v_thr, i_thr}};
  endtask : test_peak
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    test_reset();
    test_regs();
    test_zx(8'h26, 3'h2, 1'b0);
    test_zx(8'h46, 3'h4, 1'b1);
    test_zx(8'h30, 3'h3, 1'b1);
    test_zx(8'h71, 3'h7, 1'b1);
    test_zx(8'h73, 3'h7, 1'b0);
    for (int s = 0; s < 4; s++) begin
      test_peak(s[1:0], 1'b1);
      test_peak(s[1:0], 1'b0);
    end
    test_mid_reset();
    wrap_up();
  end
endmodule : tb
